// >>> src/acm_mode_ctrl.sv
/*
  Mode decode, pin reassignment, configuration select, overload detector,
  DAC power ramp and APB register file of the audio converter.
  Assumes fs_tick is a one-cycle strobe once per sample on clk, with the ADC
  samples valid in that cycle; pins are asynchronous to clk.
*/
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module acm_mode_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // apb slave
    input wire logic [acm_pkg::ACM_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // mode and multi purpose pins
    input wire logic mode_select_a,
    input wire logic mode_select_b,
    input wire logic multi_pin_one_in,
    output logic multi_pin_one_out,
    output logic multi_pin_one_oe_b,
    input wire logic [1:0] multi_pin_two,
    input wire logic multi_pin_three,
    input wire logic [1:0] multi_pin_four,
    input wire logic multi_pin_five,
    // sample stream
    input wire logic fs_tick,
    input wire logic signed [23:0] adc_left,
    input wire logic signed [23:0] adc_right,
    // control interface lines towards the serial receiver
    output logic ctrl_if_mode_line,
    output logic ctrl_if_clock_line,
    output logic ctrl_if_data_line,
    // configuration and status
    output acm_pkg::acm_cfg_t cfg,
    output logic test_mode,
    output logic [7:0] dac_gain,
    output logic ramp_active,
    output logic overload_flag_out,
    output logic irq
);
    import acm_pkg::*;

    // pin synchronisers
    acm_pins_t pins_raw;
    acm_pins_t sync1;
    acm_pins_t sync2;
    logic [1:0] p2_prev;
    logic [1:0] p4_prev;
    acm_lvl_t lvl2;
    acm_lvl_t lvl4;
    acm_lvl_t next_lvl2;
    acm_lvl_t next_lvl4;

    assign pins_raw = '{mode_select_b, mode_select_a, multi_pin_one_in, multi_pin_two,
                        multi_pin_three, multi_pin_four, multi_pin_five};

    // a three-level code is taken only when it held for two clock cycles,
    // so a pad passing through mid on its way does not leak out
    always_comb begin
        next_lvl2 = lvl2;
        next_lvl4 = lvl4;
        if (sync2.p2 == p2_prev) begin
            next_lvl2 = acm_lvl_t'(sync2.p2);
        end
        if (sync2.p4 == p4_prev) begin
            next_lvl4 = acm_lvl_t'(sync2.p4);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync1 <= '0;
            sync2 <= '0;
            p2_prev <= 2'h0;
            p4_prev <= 2'h0;
            lvl2 <= ACM_LVL_LOW;
            lvl4 <= ACM_LVL_LOW;
        end else begin
            sync1 <= pins_raw;
            sync2 <= sync1;
            p2_prev <= sync2.p2;
            p4_prev <= sync2.p4;
            lvl2 <= next_lvl2;
            lvl4 <= next_lvl4;
        end
    end

    // registers and apb
    logic [5:0] status_cfg;
    logic [4:0] play_cfg;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic [5:0] next_status_cfg;
    logic [4:0] next_play_cfg;
    logic [2:0] next_irq_stat;
    logic [2:0] next_irq_en;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [2:0] events;
    logic wr;
    logic setup;
    logic mapped;
    acm_mode_t mode;

    assign pready = psel & penable;
    assign wr = psel & penable & pwrite;
    assign setup = psel & ~penable;
    assign mapped = (paddr == ACM_OFF_STATUS_CFG) || (paddr == ACM_OFF_PLAY_CFG) ||
                    (paddr == ACM_OFF_STATE) || (paddr == ACM_OFF_IRQ_STATUS) ||
                    (paddr == ACM_OFF_IRQ_CLEAR) || (paddr == ACM_OFF_IRQ_ENABLE);
    assign irq = |(irq_stat & irq_en);

    always_comb begin
        next_status_cfg = status_cfg;
        next_play_cfg = play_cfg;
        next_irq_en = irq_en;
        next_irq_stat = irq_stat;
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (setup) begin
            next_pslverr = ~mapped;
            next_prdata = 32'h0;
            if (!pwrite) begin
                case (paddr)
                    ACM_OFF_STATUS_CFG: next_prdata = {26'h0, status_cfg};
                    ACM_OFF_PLAY_CFG: next_prdata = {27'h0, play_cfg};
                    ACM_OFF_STATE: next_prdata = {16'h0, dac_gain, 4'h0, ramp_active,
                                                  overload_flag_out, mode};
                    ACM_OFF_IRQ_STATUS: next_prdata = {29'h0, irq_stat};
                    ACM_OFF_IRQ_ENABLE: next_prdata = {29'h0, irq_en};
                    default: next_prdata = 32'h0;
                endcase
            end
        end
        if (wr) begin
            case (paddr)
                ACM_OFF_STATUS_CFG: begin
                    // unused ratio code keeps the old ratio
                    if (pwdata[5:4] != ACM_RATIO_BAD) begin
                        next_status_cfg[5:4] = pwdata[5:4];
                    end
                    next_status_cfg[3:0] = pwdata[3:0];
                end
                ACM_OFF_PLAY_CFG: next_play_cfg = pwdata[4:0];
                ACM_OFF_IRQ_ENABLE: next_irq_en = pwdata[2:0];
                ACM_OFF_IRQ_CLEAR: next_irq_stat = irq_stat & ~pwdata[2:0];
                default: next_irq_en = irq_en;
            endcase
        end
        // events win over a clear in the same cycle
        next_irq_stat = next_irq_stat | events;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            status_cfg <= ACM_STATUS_CFG_RST;
            play_cfg <= ACM_PLAY_CFG_RST;
            irq_stat <= ACM_IRQ_RST;
            irq_en <= ACM_IRQ_RST;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            status_cfg <= next_status_cfg;
            play_cfg <= next_play_cfg;
            irq_stat <= next_irq_stat;
            irq_en <= next_irq_en;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // mode decode and configuration select
    acm_mode_t next_mode;
    acm_cfg_t next_cfg;
    logic next_pin1_out;
    logic next_pin1_oe_b;
    logic [2:0] next_ctrl_lines;
    logic next_ovl_flag;
    logic ovl_rise;

    always_comb begin
        next_mode = acm_mode_t'({sync2.mode_b, sync2.mode_a});
        next_cfg = cfg;
        next_pin1_out = 1'b0;
        next_pin1_oe_b = 1'b1;
        next_ctrl_lines = 3'h0;
        case (mode)
            ACM_MODE_STATIC: begin
                next_cfg.clk_ratio = sync2.p3 ? ACM_RATIO_384 : ACM_RATIO_256;
                next_cfg.deemph = (lvl2 == ACM_LVL_MID) ? ACM_DEEMPH_44K1 : ACM_DEEMPH_NONE;
                next_cfg.mute = (lvl2 == ACM_LVL_HIGH);
                // format pins, four static formats, shared data line
                case ({sync2.p1, sync2.p5})
                    2'b00: next_cfg.fmt = ACM_FMT_MSB;
                    2'b01: next_cfg.fmt = ACM_FMT_I2S;
                    2'b10: next_cfg.fmt = ACM_FMT_MSB_LSB20;
                    default: next_cfg.fmt = ACM_FMT_MSB_LSB16;
                endcase
                next_cfg.adc_pd = (lvl4 == ACM_LVL_LOW);
                next_cfg.adc_gain_6db = (lvl4 == ACM_LVL_MID);
                next_cfg.dac_pd = 1'b0;
                next_cfg.dc_filter_en = 1'b0;
            end
            default: begin
                next_cfg.clk_ratio = acm_ratio_t'(status_cfg[5:4]);
                next_cfg.fmt = acm_fmt_t'(status_cfg[3:1]);
                next_cfg.dc_filter_en = status_cfg[0];
                next_cfg.deemph = acm_deemph_t'(play_cfg[4:3]);
                next_cfg.mute = play_cfg[2];
                next_cfg.adc_pd = ~play_cfg[1];
                next_cfg.dac_pd = ~play_cfg[0];
                next_cfg.adc_gain_6db = sync2.p5;
                // pin one drives overload, pins two to four feed control lines
                if (mode == ACM_MODE_MICRO) begin
                    next_pin1_out = next_ovl_flag;
                    next_pin1_oe_b = 1'b0;
                    next_ctrl_lines = {sync2.p2[0], sync2.p3, sync2.p4[0]};
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode <= ACM_MODE_MICRO;
            cfg <= ACM_CFG_RST;
            test_mode <= 1'b0;
            multi_pin_one_out <= 1'b0;
            multi_pin_one_oe_b <= 1'b1;
            ctrl_if_mode_line <= 1'b0;
            ctrl_if_clock_line <= 1'b0;
            ctrl_if_data_line <= 1'b0;
        end else begin
            mode <= next_mode;
            cfg <= next_cfg;
            test_mode <= (next_mode == ACM_MODE_TEST_A) || (next_mode == ACM_MODE_TEST_B);
            multi_pin_one_out <= next_pin1_out;
            multi_pin_one_oe_b <= next_pin1_oe_b;
            {ctrl_if_mode_line, ctrl_if_clock_line, ctrl_if_data_line} <= next_ctrl_lines;
        end
    end

    // overload detector
    logic [9:0] ovl_cnt;
    logic [9:0] next_ovl_cnt;
    logic ovl_hit;

    // compare against threshold on both channels
    assign ovl_hit = fs_tick && ((adc_left > ACM_OVL_TH) || (adc_left < -ACM_OVL_TH) ||
                                 (adc_right > ACM_OVL_TH) || (adc_right < -ACM_OVL_TH));

    always_comb begin
        next_ovl_cnt = ovl_cnt;
        if (ovl_hit) begin
            next_ovl_cnt = ACM_OVL_HOLD;
        end else if (fs_tick && ovl_cnt != 10'h000) begin
            next_ovl_cnt = ovl_cnt - 10'h001;
        end
        next_ovl_flag = (next_ovl_cnt != 10'h000);
        ovl_rise = next_ovl_flag & ~overload_flag_out;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ovl_cnt <= 10'h000;
            overload_flag_out <= 1'b0;
        end else begin
            ovl_cnt <= next_ovl_cnt;
            overload_flag_out <= next_ovl_flag;
        end
    end

    // dac power ramp
    acm_ramp_t ramp_st;
    acm_ramp_t next_ramp_st;
    logic [6:0] ramp_idx;
    logic [6:0] next_ramp_idx;
    logic [7:0] next_gain;
    logic ramp_done;

    always_comb begin
        next_ramp_st = ramp_st;
        next_ramp_idx = ramp_idx;
        ramp_done = 1'b0;
        case (ramp_st)
            ACM_RAMP_OFF: begin
                if (!cfg.dac_pd) begin
                    next_ramp_st = ACM_RAMP_UP;
                    next_ramp_idx = 7'h00;
                end
            end
            ACM_RAMP_UP: begin
                if (cfg.dac_pd) begin
                    // reverse from the current level, no step in the output
                    next_ramp_st = ACM_RAMP_DOWN;
                    next_ramp_idx = ACM_RAMP_LAST - ramp_idx;
                end else if (fs_tick) begin
                    if (ramp_idx == ACM_RAMP_LAST) begin
                        next_ramp_st = ACM_RAMP_ON;
                        ramp_done = 1'b1;
                    end else begin
                        next_ramp_idx = ramp_idx + 7'h01;
                    end
                end
            end
            ACM_RAMP_ON: begin
                if (cfg.dac_pd) begin
                    next_ramp_st = ACM_RAMP_DOWN;
                    next_ramp_idx = 7'h00;
                end
            end
            ACM_RAMP_DOWN: begin
                if (!cfg.dac_pd) begin
                    next_ramp_st = ACM_RAMP_UP;
                    next_ramp_idx = ACM_RAMP_LAST - ramp_idx;
                end else if (fs_tick) begin
                    if (ramp_idx == ACM_RAMP_LAST) begin
                        next_ramp_st = ACM_RAMP_OFF;
                        ramp_done = 1'b1;
                    end else begin
                        next_ramp_idx = ramp_idx + 7'h01;
                    end
                end
            end
            default: next_ramp_st = ACM_RAMP_OFF;
        endcase
        case (next_ramp_st)
            ACM_RAMP_UP: next_gain = ACM_COS_TABLE[next_ramp_idx[6:2]];
            ACM_RAMP_DOWN: next_gain = ACM_COS_TABLE[5'h1F - next_ramp_idx[6:2]];
            ACM_RAMP_ON: next_gain = ACM_GAIN_FULL;
            default: next_gain = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ramp_st <= ACM_RAMP_OFF;
            ramp_idx <= 7'h00;
            dac_gain <= 8'h00;
            ramp_active <= 1'b0;
        end else begin
            ramp_st <= next_ramp_st;
            ramp_idx <= next_ramp_idx;
            dac_gain <= next_gain;
            ramp_active <= (next_ramp_st == ACM_RAMP_UP) || (next_ramp_st == ACM_RAMP_DOWN);
        end
    end

    assign events = {next_mode != mode, ramp_done, ovl_rise};

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_STATIC_DECODE: assert property (({mode_select_b, mode_select_a} == 2'b11) [*4]
        |=> mode == ACM_MODE_STATIC) else $error("static mode not decoded");
    AST_PIN1_OVL: assert property ($past(rst_b) && $past(mode) == ACM_MODE_MICRO |->
        !multi_pin_one_oe_b && multi_pin_one_out == overload_flag_out)
        else $error("pin one not carrying overload");
    AST_OVL_DETECT: assert property (fs_tick && adc_left > ACM_OVL_TH
        |=> overload_flag_out) else $error("overload missed");
    AST_OVL_HOLD: assert property ($fell(overload_flag_out) |->
        $past(ovl_cnt) == 10'h001 && $past(fs_tick)) else $error("overload dropped early");
    AST_OVL_RESTART: assert property (ovl_hit |=> ovl_cnt == ACM_OVL_HOLD)
        else $error("hold not restarted");
    AST_RAMP_END: assert property (ramp_st == ACM_RAMP_UP && !cfg.dac_pd && fs_tick &&
        ramp_idx == ACM_RAMP_LAST |=> ramp_st == ACM_RAMP_ON && dac_gain == ACM_GAIN_FULL)
        else $error("ramp up did not end at full gain");
    AST_RAMP_START: assert property (ramp_st == ACM_RAMP_ON && cfg.dac_pd
        |=> ramp_st == ACM_RAMP_DOWN && ramp_idx == 7'h00 ##1 ramp_active)
        else $error("ramp down not started");
    AST_STATIC_CLK: assert property (mode == ACM_MODE_STATIC && sync2.p3
        |=> cfg.clk_ratio == ACM_RATIO_384) else $error("static ratio wrong");
    AST_STATIC_ADC: assert property (mode == ACM_MODE_STATIC && lvl4 == ACM_LVL_LOW
        |=> cfg.adc_pd && !cfg.adc_gain_6db) else $error("static adc power-down wrong");
    AST_NO_DC_STATIC: assert property (mode == ACM_MODE_STATIC |=> !cfg.dc_filter_en)
        else $error("dc filter on in static mode");
    AST_MICRO_GAIN: assert property (mode == ACM_MODE_MICRO && sync2.p5
        |=> cfg.adc_gain_6db) else $error("gain pin ignored");

    COV_RAMP_UP: cover property (ramp_st == ACM_RAMP_UP ##1 ramp_st == ACM_RAMP_ON);
    COV_RAMP_DOWN: cover property (ramp_st == ACM_RAMP_DOWN ##1 ramp_st == ACM_RAMP_OFF);
    COV_OVERLOAD: cover property ($fell(overload_flag_out));
    COV_STATIC: cover property (mode == ACM_MODE_STATIC && lvl2 == ACM_LVL_MID);

endmodule

// >>> src/acm_pkg.sv
/*
  Constants, types and register map of the audio converter mode control block.
  Assumes a single system clock domain and an APB master for software access.
*/
// Overview of operation
// - cosine ramp over 128 samples on DAC power
// - mode pins pick microcontroller, static or test
// - microcontroller mode reassigns the five multi pins
// - microcontroller clock ratio 256, 384 or 512
// - microcontroller serial formats programmed by software
// - both channels share one serial data line
// - pin five low 0 dB, high 6 dB
// - overload when sample beyond -1.16 dB
// - overload output high at least 512 samples
// - each overload restarts the hold count
// - DC filter only under software control
// - static clock pin low 256, high 384
// - static playback pin: none, 44.1k de-emphasis, mute
// - static format pins one and five decode
// - static mode offers four serial formats
// - static ADC pin: power-down, 6 dB, 0 dB
package acm_pkg;

    localparam int ACM_ADDR_W = 8;
    localparam logic [7:0] ACM_OFF_STATUS_CFG = 8'h00;
    localparam logic [7:0] ACM_OFF_PLAY_CFG = 8'h04;
    localparam logic [7:0] ACM_OFF_STATE = 8'h08;
    localparam logic [7:0] ACM_OFF_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] ACM_OFF_IRQ_CLEAR = 8'h10;
    localparam logic [7:0] ACM_OFF_IRQ_ENABLE = 8'h14;

    // status cfg: [5:4] clock ratio, [3:1] format, [0] dc filter
    localparam logic [5:0] ACM_STATUS_CFG_RST = 6'h20;
    // play cfg: [4:3] de-emphasis, [2] mute, [1] adc on, [0] dac on
    localparam logic [4:0] ACM_PLAY_CFG_RST = 5'h03;
    localparam logic [2:0] ACM_IRQ_RST = 3'h0;
    localparam int ACM_IRQ_OVL = 0;
    localparam int ACM_IRQ_RAMP = 1;
    localparam int ACM_IRQ_MODE = 2;

    localparam logic [9:0] ACM_OVL_HOLD = 10'h200;
    localparam logic signed [23:0] ACM_OVL_TH = 24'sh700000;
    localparam logic [6:0] ACM_RAMP_LAST = 7'h7F;
    localparam logic [7:0] ACM_GAIN_FULL = 8'hFF;

    typedef enum logic [1:0] {
        ACM_MODE_MICRO = 2'b00,
        ACM_MODE_TEST_A = 2'b01,
        ACM_MODE_TEST_B = 2'b10,
        ACM_MODE_STATIC = 2'b11
    } acm_mode_t;

    typedef enum logic [1:0] {
        ACM_RATIO_512 = 2'b00,
        ACM_RATIO_384 = 2'b01,
        ACM_RATIO_256 = 2'b10,
        ACM_RATIO_BAD = 2'b11
    } acm_ratio_t;

    typedef enum logic [2:0] {
        ACM_FMT_I2S = 3'b000,
        ACM_FMT_LSB16 = 3'b001,
        ACM_FMT_LSB18 = 3'b010,
        ACM_FMT_LSB20 = 3'b011,
        ACM_FMT_MSB = 3'b100,
        ACM_FMT_MSB_LSB16 = 3'b101,
        ACM_FMT_MSB_LSB18 = 3'b110,
        ACM_FMT_MSB_LSB20 = 3'b111
    } acm_fmt_t;

    typedef enum logic [1:0] {
        ACM_DEEMPH_NONE = 2'b00,
        ACM_DEEMPH_32K = 2'b01,
        ACM_DEEMPH_44K1 = 2'b10,
        ACM_DEEMPH_48K = 2'b11
    } acm_deemph_t;

    // three-level pad comparator code
    typedef enum logic [1:0] {
        ACM_LVL_LOW = 2'b00,
        ACM_LVL_MID = 2'b01,
        ACM_LVL_HIGH = 2'b11
    } acm_lvl_t;

    typedef enum logic [1:0] {
        ACM_RAMP_OFF = 2'b00,
        ACM_RAMP_UP = 2'b01,
        ACM_RAMP_ON = 2'b10,
        ACM_RAMP_DOWN = 2'b11
    } acm_ramp_t;

    typedef struct packed {
        acm_ratio_t clk_ratio;
        acm_fmt_t fmt;
        acm_deemph_t deemph;
        logic mute;
        logic adc_gain_6db;
        logic adc_pd;
        logic dac_pd;
        logic dc_filter_en;
    } acm_cfg_t;

    typedef struct packed {
        logic mode_b;
        logic mode_a;
        logic p1;
        logic [1:0] p2;
        logic p3;
        logic [1:0] p4;
        logic p5;
    } acm_pins_t;

    localparam acm_cfg_t ACM_CFG_RST = '{ACM_RATIO_256, ACM_FMT_I2S, ACM_DEEMPH_NONE,
                                         1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

    // rising half cosine, one entry per four samples
    localparam logic [7:0] ACM_COS_TABLE [32] = '{
        8'h00, 8'h01, 8'h02, 8'h05, 8'h0A, 8'h0F, 8'h15, 8'h1D,
        8'h25, 8'h2F, 8'h39, 8'h43, 8'h4F, 8'h5A, 8'h67, 8'h73,
        8'h80, 8'h8C, 8'h98, 8'hA5, 8'hB0, 8'hBC, 8'hC6, 8'hD0,
        8'hDA, 8'hE2, 8'hEA, 8'hF0, 8'hF5, 8'hFA, 8'hFD, 8'hFE
    };

endpackage

// >>> test/acm_strap_model.sv
/*
  Board side of the mode pins: host or strap setting the pin levels.
  Assumes the device drives multi pin one only while its enable is low.
*/
`timescale 1ns/1ps
module acm_strap_model (
    // requested strap levels
    input acm_pkg::acm_pins_t req,
    // device side of pin one
    input wire logic multi_pin_one_out,
    input wire logic multi_pin_one_oe_b,
    // pin levels seen by the device
    output logic mode_select_a,
    output logic mode_select_b,
    output logic multi_pin_one_in,
    output logic [1:0] multi_pin_two,
    output logic multi_pin_three,
    output logic [1:0] multi_pin_four,
    output logic multi_pin_five
);
    import acm_pkg::*;
    assign mode_select_a = req.mode_a;
    assign mode_select_b = req.mode_b;
    // shared pin one
    // the strap only shows while the device has let go of the pin
    assign multi_pin_one_in = multi_pin_one_oe_b ? req.p1 : multi_pin_one_out;
    assign multi_pin_two = req.p2;
    assign multi_pin_three = req.p3;
    assign multi_pin_four = req.p4;
    assign multi_pin_five = req.p5;
endmodule

// >>> test/tb.sv
/*
  Self-checking bench of the mode control block with a strap model.
  Assumes zero-wait APB and a fs_tick strobe driven every other cycle.
*/
`timescale 1ns/1ps
module tb;
    import acm_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fs_tick = 1'b0, perr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rdata;
    logic signed [23:0] adc_left = 24'sh0, adc_right = 24'sh0;
    acm_pins_t req = '0;
    wire pready, pslverr, multi_pin_one_in, multi_pin_one_out, multi_pin_one_oe_b;
    wire mode_select_a, mode_select_b, multi_pin_three, multi_pin_five, irq;
    wire ctrl_if_mode_line, ctrl_if_clock_line, ctrl_if_data_line;
    wire test_mode, ramp_active, overload_flag_out;
    wire [1:0] multi_pin_two, multi_pin_four;
    wire [31:0] prdata;
    wire [7:0] dac_gain;
    acm_cfg_t cfg;
    int failures = 0, checks = 0, m, j, k;
    logic [1:0] lv [3] = '{ACM_LVL_LOW, ACM_LVL_MID, ACM_LVL_HIGH};
    logic [1:0] rt [3] = '{ACM_RATIO_512, ACM_RATIO_384, ACM_RATIO_256};

    always #5 clk = ~clk;

    acm_mode_ctrl u_acm_mode_ctrl (.clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata,
        .pready, .prdata, .pslverr, .mode_select_a, .mode_select_b, .multi_pin_one_in,
        .multi_pin_one_out, .multi_pin_one_oe_b, .multi_pin_two, .multi_pin_three,
        .multi_pin_four, .multi_pin_five, .fs_tick, .adc_left, .adc_right, .ctrl_if_mode_line,
        .ctrl_if_clock_line, .ctrl_if_data_line, .cfg, .test_mode, .dac_gain, .ramp_active,
        .overload_flag_out, .irq);
    acm_strap_model u_acm_strap_model (.req, .multi_pin_one_out, .multi_pin_one_oe_b,
        .mode_select_a, .mode_select_b, .multi_pin_one_in, .multi_pin_two, .multi_pin_three,
        .multi_pin_four, .multi_pin_five);

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task test_done;
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdata = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // samples stay within the threshold, at times exactly on it
    function automatic logic signed [23:0] rnd();
        logic signed [23:0] v;
        v = ($urandom % 4 == 0) ? 24'sh700000 : 24'($urandom_range(0, 24'h700000));
        return ($urandom % 2) ? -v : v;
    endfunction

    // frame strobe moves after the rising edge, once per frame
    task tick(input int n, input logic [1:0] hit);
        repeat (n) begin
            @(posedge clk);
            fs_tick <= 1'b1;
            adc_left <= hit[0] ? 24'sh700001 : rnd();
            adc_right <= hit[1] ? -24'sh700001 : rnd();
            @(posedge clk);
            fs_tick <= 1'b0;
        end
        #1;
    endtask

    function automatic acm_fmt_t sfmt(logic a, logic b);
        case ({a, b})
            2'b00: return ACM_FMT_MSB;
            2'b01: return ACM_FMT_I2S;
            2'b10: return ACM_FMT_MSB_LSB20;
            default: return ACM_FMT_MSB_LSB16;
        endcase
    endfunction

    initial begin
        #300000;
        failures++;
        test_done;
    end

    initial begin
        void'($urandom(69));
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        apb(0, ACM_OFF_STATUS_CFG, 0);
        chk(rdata, 32'h20);
        apb(0, ACM_OFF_PLAY_CFG, 0);
        chk(rdata, 32'h03);
        apb(0, 8'h18, 0);
        chk(perr, 1);
        chk(rdata, 32'h0);
        wt(4);
        chk(ramp_active, 1);
        tick(127, 0);
        chk({ramp_active, dac_gain == 8'hFF}, 2'b10);
        tick(1, 0);
        wt(1);
        chk({ramp_active, dac_gain}, {1'b0, 8'hFF});
        apb(0, ACM_OFF_IRQ_STATUS, 0);
        chk(rdata[1], 1);
        wt(1);
        chk(irq, 0);
        apb(1, ACM_OFF_IRQ_ENABLE, 2);
        wt(1);
        chk(irq, 1);
        apb(1, ACM_OFF_IRQ_CLEAR, 7);
        wt(1);
        chk(irq, 0);
        apb(1, ACM_OFF_PLAY_CFG, 2);
        wt(3);
        chk(ramp_active, 1);
        tick(128, 0);
        wt(1);
        chk({ramp_active, dac_gain}, 9'h0);
        apb(1, ACM_OFF_IRQ_ENABLE, 1);
        tick(40, 0);
        chk({overload_flag_out, irq}, 0);
        tick(1, 2'b10);
        chk({overload_flag_out, multi_pin_one_out, irq}, 3'b111);
        tick(300, 0);
        apb(0, ACM_OFF_STATE, 0);
        chk(rdata, 32'h4);
        tick(1, 2'b01);
        tick(511, 0);
        chk(overload_flag_out, 1);
        tick(1, 0);
        wt(1);
        chk({overload_flag_out, multi_pin_one_out}, 0);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            req <= acm_pins_t'({2'b00, 7'($urandom)});
            apb(1, ACM_OFF_STATUS_CFG, {26'h0, rt[i % 3], 3'(i), 1'(i)});
            wt(8);
            chk({cfg.clk_ratio, cfg.fmt, cfg.dc_filter_en}, {rt[i % 3], 3'(i), 1'(i)});
            chk(cfg.adc_gain_6db, req.p5);
            chk({ctrl_if_mode_line, ctrl_if_clock_line, ctrl_if_data_line},
                {req.p2[0], req.p3, req.p4[0]});
        end
        apb(1, ACM_OFF_STATUS_CFG, 32'h30);
        apb(0, ACM_OFF_STATUS_CFG, 0);
        chk(rdata, 32'h10);
        apb(1, ACM_OFF_PLAY_CFG, 32'h1C);
        wt(2);
        chk({cfg.deemph, cfg.mute, cfg.adc_pd, cfg.dac_pd}, {ACM_DEEMPH_48K, 3'b111});
        for (int i = 0; i < 12; i++) begin
            m = (i < 4) ? i : 3;
            j = $urandom_range(0, 2);
            k = $urandom_range(0, 2);
            @(posedge clk);
            req <= '{m[1], m[0], 1'($urandom), lv[j], 1'($urandom), lv[k], 1'($urandom)};
            wt(8);
            chk({test_mode, multi_pin_one_oe_b}, {m == 1 || m == 2, m != 0});
            if (m == 3) begin
                chk(cfg.clk_ratio, req.p3 ? ACM_RATIO_384 : ACM_RATIO_256);
                chk(cfg.fmt, sfmt(req.p1, req.p5));
                chk({cfg.deemph, cfg.mute}, {j == 1 ? ACM_DEEMPH_44K1 : ACM_DEEMPH_NONE, j == 2});
                chk({cfg.adc_pd, cfg.adc_gain_6db}, {k == 0, k == 1});
            end
        end
        test_done;
    end
endmodule
